// [src/urc_core.sv]
// Serial transceiver core with its host register file and modem lines.
// Function
// - Holding register loads when holding or shifter empty.
// - Holding-empty flag set on idle or transfer.
// - Validate start bit at mid-bit sample.
// - Enable bits gate four sources; upper zero.
// - Identification read clears only shown source.
// - Lower source hidden until higher serviced.
// - Identification codes 0110, 0100, 0010, 0000.
// - Bit 0 low when pending; upper zero.
// - Bits 1..0 select five to eight bits.
// - Stop bit count one, one and a half, two.
// - Bit 3 adds and checks parity.
// - Bit 4 picks odd or even parity.
// - Bit 5 forces parity to fixed level.
// - Bit 6 holds serial output low, except in loopback where it stays high.
// - Bit 7 maps addresses to divisor latch.
// - Control bits drive ready and send outputs.
// - Control bits drive two general outputs.
// - Bit 4 enables loopback; upper zero.
// - Completed character moves to receive holding.
// - Status bit 0 shows data waiting.
// - Overrun sets flag, keeps held byte.
// - Loopback joins serial and modem lines.
// - Status bits flag parity, framing, break.
// - Modem changes set deltas; read clears.
`timescale 1ns/100ps
module urc_core (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       cs,
	input  wire logic [2:0] addr,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	output logic            irq,
	input  wire logic       serial_in,
	output logic            serial_out,
	input  wire logic       cts_n,
	input  wire logic       dsr_n,
	input  wire logic       ri_n,
	input  wire logic       cd_n,
	output logic            dtr_n,
	output logic            rts_n,
	output logic            general_output_a_n,
	output logic            general_output_b_n
);
	logic [7:0] interrupt_enable_ff;
	logic [7:0] line_format_control_ff;
	logic [7:0] modem_line_control_ff;
	logic [7:0] receive_holding_ff;
	logic [7:0] scratch_ff;
	logic [7:0] div_lo_ff;
	logic [7:0] div_hi_ff;
	logic [7:0] rdata_ff;
	logic       rd_n_ff;
	logic       wr_n_ff;
	logic       dr_ff;
	logic [3:0] err_ff;
	logic [3:0] delta_ff;
	logic [3:0] mdm_prev_ff;
	logic       mdm_armed_ff;
	logic [3:0] pend_ff;
	logic       tick;

	// Host strobes act once, on their falling edge.
	wire rd_pulse = cs & ~rd_n & rd_n_ff;
	wire wr_pulse = cs & ~wr_n & wr_n_ff;
	wire dlab     = line_format_control_ff[urc_pkg::LFC_DLAB];
	wire rd_hold  = rd_pulse & (addr == urc_pkg::ADDR_HOLD) & ~dlab;
	wire wr_hold  = wr_pulse & (addr == urc_pkg::ADDR_HOLD) & ~dlab;
	wire rd_ident = rd_pulse & (addr == urc_pkg::ADDR_IDENT);
	wire rd_stat  = rd_pulse & (addr == urc_pkg::ADDR_STATUS);
	wire rd_mstat = rd_pulse & (addr == urc_pkg::ADDR_MSTAT);
	wire wr_ena   = wr_pulse & (addr == urc_pkg::ADDR_ENABLE) & ~dlab;
	wire wr_lfc   = wr_pulse & (addr == urc_pkg::ADDR_LFC);
	wire wr_mlc   = wr_pulse & (addr == urc_pkg::ADDR_MLC);
	wire wr_scr   = wr_pulse & (addr == urc_pkg::ADDR_SCRATCH);
	wire wr_dlo   = wr_pulse & (addr == urc_pkg::ADDR_DIV_LO) & dlab;
	wire wr_dhi   = wr_pulse & (addr == urc_pkg::ADDR_DIV_HI) & dlab;

	// Character format shared by both directions.
	wire [1:0] wlen     = line_format_control_ff[1:0];
	wire [2:0] last_bit = {1'b1, wlen};
	wire [7:0] dmask    = 8'hff >> (2'h3 - wlen);
	wire       par_en   = line_format_control_ff[urc_pkg::LFC_PAR_EN];
	wire       loop     = modem_line_control_ff[urc_pkg::MLC_LOOP];

	function automatic logic par_of(input logic [7:0] d, input logic [7:0] fmt);
		logic even;
		even = fmt[urc_pkg::LFC_EVEN];
		if (fmt[urc_pkg::LFC_FORCE])
			par_of = ~even;
		else
			par_of = even ? ^d : ~^d;
	endfunction

	urc_baud #(
		.W(16)
	) u_baud (
		.clk     (clk),
		.arst_n  (arst_n),
		.divisor ({div_hi_ff, div_lo_ff}),
		.tick    (tick)
	);

	// Transmit path: holding entry in the buffer, then the shifter.
	urc_pkg::urc_tx_state_t tx_state_ff;
	logic [7:0] transmit_shifter_ff;
	logic [5:0] tx_cnt_ff;
	logic [2:0] tx_bit_ff;
	logic       tx_line_ff;
	logic [7:0] buf_data;
	logic       buf_valid;
	logic       buf_in_ready;
	wire        tx_idle  = (tx_state_ff == urc_pkg::URC_TX_IDLE);
	wire        tx_load  = tx_idle & buf_valid;
	wire        hold_empty = ~buf_valid;
	wire        tx_empty   = hold_empty & tx_idle;
	// A write is taken while holding entry or shifter is free; otherwise it is dropped.
	wire        tx_push    = wr_hold & (hold_empty | tx_idle) & buf_in_ready;
	wire        tx_bit_end = tick & (tx_cnt_ff == urc_pkg::TICKS_BIT - 6'h01);
	wire [5:0]  stop_ticks = ~line_format_control_ff[urc_pkg::LFC_STOP] ? urc_pkg::TICKS_BIT :
		(wlen == 2'h0) ? urc_pkg::TICKS_STOP15 : urc_pkg::TICKS_STOP2;

	urc_buffer #(
		.WIDTH(8),
		.DEPTH(2)
	) u_tx_buf (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_data   (wdata),
		.in_valid  (tx_push),
		.in_ready  (buf_in_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (tx_idle)
	);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_state_ff         <= urc_pkg::URC_TX_IDLE;
			transmit_shifter_ff <= 8'h00;
			tx_cnt_ff           <= 6'h00;
			tx_bit_ff           <= 3'h0;
			tx_line_ff          <= 1'b1;
		end
		else
		begin
			case (tx_state_ff)
				urc_pkg::URC_TX_IDLE:
				begin
					tx_line_ff <= 1'b1;
					if (tx_load)
					begin
						transmit_shifter_ff <= buf_data & dmask;
						tx_state_ff         <= urc_pkg::URC_TX_START;
						tx_cnt_ff           <= 6'h00;
						tx_line_ff          <= 1'b0;
					end
				end
				urc_pkg::URC_TX_START, urc_pkg::URC_TX_DATA, urc_pkg::URC_TX_PAR:
				begin
					if (tick)
						tx_cnt_ff <= tx_cnt_ff + 6'h01;
					if (tx_bit_end)
					begin
						tx_cnt_ff <= 6'h00;
						if (tx_state_ff == urc_pkg::URC_TX_START)
						begin
							tx_state_ff <= urc_pkg::URC_TX_DATA;
							tx_bit_ff   <= 3'h0;
							tx_line_ff  <= transmit_shifter_ff[0];
						end
						else if (tx_state_ff == urc_pkg::URC_TX_DATA && tx_bit_ff != last_bit)
						begin
							tx_bit_ff  <= tx_bit_ff + 3'h1;
							tx_line_ff <= transmit_shifter_ff[tx_bit_ff + 3'h1];
						end
						else if (tx_state_ff == urc_pkg::URC_TX_DATA && par_en)
						begin
							tx_state_ff <= urc_pkg::URC_TX_PAR;
							tx_line_ff  <= par_of(transmit_shifter_ff, line_format_control_ff);
						end
						else
						begin
							tx_state_ff <= urc_pkg::URC_TX_STOP;
							tx_line_ff  <= 1'b1;
						end
					end
				end
				urc_pkg::URC_TX_STOP:
				begin
					if (tick)
						tx_cnt_ff <= tx_cnt_ff + 6'h01;
					if (tick && tx_cnt_ff == stop_ticks - 6'h01)
						tx_state_ff <= urc_pkg::URC_TX_IDLE;
				end
				default:
					tx_state_ff <= urc_pkg::URC_TX_IDLE;
			endcase
		end
	end

	wire tx_wire = tx_line_ff & ~line_format_control_ff[urc_pkg::LFC_BREAK];
	assign serial_out = loop ? 1'b1 : tx_wire;

	// Receive path.
	urc_pkg::urc_rx_state_t rx_state_ff;
	logic [7:0] rx_shift_ff;
	logic [5:0] rx_cnt_ff;
	logic [2:0] rx_bit_ff;
	logic       rx_par_ff;
	logic       rx_prev_ff;
	wire        rx_in     = loop ? tx_wire : serial_in;
	wire        rx_sample = tick & (rx_cnt_ff == urc_pkg::TICKS_BIT - 6'h01);
	wire        rx_done   = rx_sample & (rx_state_ff == urc_pkg::URC_RX_STOP);
	wire        fe_now    = ~rx_in;
	wire        pe_now    = par_en & (rx_par_ff != par_of(rx_shift_ff, line_format_control_ff));
	wire        bi_now    = (rx_shift_ff == 8'h00) & ~rx_in & ~(par_en & rx_par_ff);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_state_ff <= urc_pkg::URC_RX_IDLE;
			rx_shift_ff <= 8'h00;
			rx_cnt_ff   <= 6'h00;
			rx_bit_ff   <= 3'h0;
			rx_par_ff   <= 1'b0;
			rx_prev_ff  <= 1'b1;
		end
		else
		begin
			rx_prev_ff <= rx_in;
			if (tick && rx_state_ff != urc_pkg::URC_RX_IDLE)
				rx_cnt_ff <= rx_cnt_ff + 6'h01;
			case (rx_state_ff)
				urc_pkg::URC_RX_IDLE:
				begin
					if (rx_prev_ff && !rx_in)
					begin
						rx_state_ff <= urc_pkg::URC_RX_START;
						rx_cnt_ff   <= 6'h00;
						rx_shift_ff <= 8'h00;
					end
				end
				urc_pkg::URC_RX_START:
				begin
					// The edge is seen in the cycle it arrives, so eight ticks later this lands mid start bit.
					if (tick && rx_cnt_ff == urc_pkg::TICKS_START - 6'h01)
					begin
						rx_cnt_ff   <= 6'h00;
						rx_bit_ff   <= 3'h0;
						rx_state_ff <= rx_in ? urc_pkg::URC_RX_IDLE : urc_pkg::URC_RX_DATA;
					end
				end
				urc_pkg::URC_RX_DATA:
				begin
					if (rx_sample)
					begin
						rx_cnt_ff              <= 6'h00;
						rx_shift_ff[rx_bit_ff] <= rx_in;
						rx_bit_ff              <= rx_bit_ff + 3'h1;
						if (rx_bit_ff == last_bit)
							rx_state_ff <= par_en ? urc_pkg::URC_RX_PAR : urc_pkg::URC_RX_STOP;
					end
				end
				urc_pkg::URC_RX_PAR:
				begin
					if (rx_sample)
					begin
						rx_cnt_ff   <= 6'h00;
						rx_par_ff   <= rx_in;
						rx_state_ff <= urc_pkg::URC_RX_STOP;
					end
				end
				urc_pkg::URC_RX_STOP:
				begin
					if (rx_sample)
						rx_state_ff <= urc_pkg::URC_RX_IDLE;
				end
				default:
					rx_state_ff <= urc_pkg::URC_RX_IDLE;
			endcase
		end
	end

	// Receive holding and line status; hardware sets win over read clears.
	wire       rx_load = rx_done & ~dr_ff;
	wire [3:0] err_set = {bi_now, fe_now, pe_now, dr_ff} & {4{rx_done}};

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			receive_holding_ff <= 8'h00;
			dr_ff              <= 1'b0;
			err_ff             <= 4'h0;
		end
		else
		begin
			if (rx_load)
				receive_holding_ff <= rx_shift_ff;
			dr_ff  <= rx_done | (dr_ff & ~rd_hold);
			err_ff <= err_set | (err_ff & ~{4{rd_stat}});
		end
	end

	// Modem inputs as active-high levels, in status bit order cts, dsr, ri, cd.
	wire [3:0] mdm_now = loop ? {modem_line_control_ff[3], modem_line_control_ff[2],
		modem_line_control_ff[0], modem_line_control_ff[1]} :
		~{cd_n, ri_n, dsr_n, cts_n};
	wire [3:0] mdm_chg = mdm_prev_ff ^ mdm_now;
	// Ring indicator reports only its trailing edge.
	wire [3:0] delta_set = {mdm_chg[3], mdm_chg[2] & mdm_prev_ff[2], mdm_chg[1:0]}
		& {4{mdm_armed_ff}};

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mdm_prev_ff  <= 4'h0;
			mdm_armed_ff <= 1'b0;
			delta_ff     <= 4'h0;
		end
		else
		begin
			mdm_prev_ff  <= mdm_now;
			mdm_armed_ff <= 1'b1;
			delta_ff     <= delta_set | (delta_ff & ~{4{rd_mstat}});
		end
	end

	// Pending sources in order line, receive, transmit, modem.
	logic hold_empty_ff;
	wire [3:0] active  = pend_ff & {interrupt_enable_ff[2], interrupt_enable_ff[0],
		interrupt_enable_ff[1], interrupt_enable_ff[3]};
	wire [3:0] top     = active[3] ? 4'h8 : active[2] ? 4'h4 :
		active[1] ? 4'h2 : active[0] ? 4'h1 : 4'h0;
	wire [3:0] id_code = active[3] ? urc_pkg::ID_LINE : active[2] ? urc_pkg::ID_RXRD :
		active[1] ? urc_pkg::ID_TXEM : active[0] ? urc_pkg::ID_MDM : urc_pkg::ID_NONE;
	wire [3:0] evt     = {|err_set, rx_done, hold_empty & ~hold_empty_ff, |delta_set};
	wire [3:0] clr     = ({4{rd_ident}} & top) |
		{rd_stat, rd_hold, wr_hold, rd_mstat};

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pend_ff       <= 4'h0;
			hold_empty_ff <= 1'b1;
		end
		else
		begin
			pend_ff       <= evt | (pend_ff & ~clr);
			hold_empty_ff <= hold_empty;
		end
	end

	assign irq = |active;

	// Host register writes.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			interrupt_enable_ff    <= urc_pkg::RST_ENABLE;
			line_format_control_ff <= urc_pkg::RST_LFC;
			modem_line_control_ff  <= urc_pkg::RST_MLC;
			scratch_ff             <= urc_pkg::RST_SCRATCH;
			div_lo_ff              <= urc_pkg::RST_DIV;
			div_hi_ff              <= 8'h00;
		end
		else
		begin
			if (wr_ena)
				interrupt_enable_ff <= {4'h0, wdata[3:0]};
			if (wr_lfc)
				line_format_control_ff <= wdata;
			if (wr_mlc)
				modem_line_control_ff <= {3'h0, wdata[4:0]};
			if (wr_scr)
				scratch_ff <= wdata;
			if (wr_dlo)
				div_lo_ff <= wdata;
			if (wr_dhi)
				div_hi_ff <= wdata;
		end
	end

	// Read data is captured at the strobe edge and held until the next read.
	wire [7:0] status_val = {1'b0, tx_empty, hold_empty, err_ff, dr_ff};
	wire [7:0] rd_mux     =
		(dlab && addr == urc_pkg::ADDR_DIV_LO) ? div_lo_ff :
		(dlab && addr == urc_pkg::ADDR_DIV_HI) ? div_hi_ff :
		(addr == urc_pkg::ADDR_HOLD)    ? receive_holding_ff :
		(addr == urc_pkg::ADDR_ENABLE)  ? interrupt_enable_ff :
		(addr == urc_pkg::ADDR_IDENT)   ? {4'h0, id_code} :
		(addr == urc_pkg::ADDR_LFC)     ? line_format_control_ff :
		(addr == urc_pkg::ADDR_MLC)     ? modem_line_control_ff :
		(addr == urc_pkg::ADDR_STATUS)  ? status_val :
		(addr == urc_pkg::ADDR_MSTAT)   ? {mdm_now, delta_ff} : scratch_ff;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_n_ff  <= 1'b1;
			wr_n_ff  <= 1'b1;
			rdata_ff <= 8'h00;
		end
		else
		begin
			rd_n_ff <= rd_n | ~cs;
			wr_n_ff <= wr_n | ~cs;
			if (rd_pulse)
				rdata_ff <= rd_mux;
		end
	end

	assign rdata              = rdata_ff;
	assign dtr_n              = ~modem_line_control_ff[0];
	assign rts_n              = ~modem_line_control_ff[1];
	assign general_output_a_n = ~modem_line_control_ff[2];
	assign general_output_b_n = ~modem_line_control_ff[3];
endmodule

// [src/urc_pkg.sv]
// Shared constants, register map and state types of the serial register core.
package urc_pkg;
	// Register offsets on the three address pins.
	localparam logic [2:0] ADDR_HOLD    = 3'h0;
	localparam logic [2:0] ADDR_ENABLE  = 3'h1;
	localparam logic [2:0] ADDR_IDENT   = 3'h2;
	localparam logic [2:0] ADDR_LFC     = 3'h3;
	localparam logic [2:0] ADDR_MLC     = 3'h4;
	localparam logic [2:0] ADDR_STATUS  = 3'h5;
	localparam logic [2:0] ADDR_MSTAT   = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH = 3'h7;
	localparam logic [2:0] ADDR_DIV_LO  = 3'h0;
	localparam logic [2:0] ADDR_DIV_HI  = 3'h1;
	// Values after reset.
	localparam logic [7:0] RST_ENABLE   = 8'h00;
	localparam logic [7:0] RST_LFC      = 8'h00;
	localparam logic [7:0] RST_MLC      = 8'h00;
	localparam logic [7:0] RST_SCRATCH  = 8'hff;
	localparam logic [7:0] RST_DIV      = 8'h01;
	// Field positions.
	localparam int LFC_STOP   = 2;
	localparam int LFC_PAR_EN = 3;
	localparam int LFC_EVEN   = 4;
	localparam int LFC_FORCE  = 5;
	localparam int LFC_BREAK  = 6;
	localparam int LFC_DLAB   = 7;
	localparam int MLC_LOOP   = 4;
	// Identification codes in bits 3..0, priority 1 first.
	localparam logic [3:0] ID_LINE = 4'h6;
	localparam logic [3:0] ID_RXRD = 4'h4;
	localparam logic [3:0] ID_TXEM = 4'h2;
	localparam logic [3:0] ID_MDM  = 4'h0;
	localparam logic [3:0] ID_NONE = 4'h1;
	// Counts of 16x sample ticks.
	localparam logic [5:0] TICKS_BIT    = 6'h10;
	localparam logic [5:0] TICKS_START  = 6'h08;
	localparam logic [5:0] TICKS_STOP15 = 6'h18;
	localparam logic [5:0] TICKS_STOP2  = 6'h20;
	typedef enum logic [4:0] {
		URC_TX_IDLE  = 5'h01,
		URC_TX_START = 5'h02,
		URC_TX_DATA  = 5'h04,
		URC_TX_PAR   = 5'h08,
		URC_TX_STOP  = 5'h10
	} urc_tx_state_t;
	typedef enum logic [4:0] {
		URC_RX_IDLE  = 5'h01,
		URC_RX_START = 5'h02,
		URC_RX_DATA  = 5'h04,
		URC_RX_PAR   = 5'h08,
		URC_RX_STOP  = 5'h10
	} urc_rx_state_t;
endpackage

// [src/urc_buffer.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module urc_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;
	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data  = mem_ff[rd_ptr_ff];
	always_ff @(posedge clk)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [src/urc_baud.sv]
// Divisor counter giving the one-cycle 16x sample enable.
`timescale 1ns/100ps
module urc_baud #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] divisor,
	output logic              tick
);
	logic [W-1:0] cnt_ff;
	// A divisor of zero behaves as one so the block never stalls.
	wire  [W-1:0] last = (divisor == '0) ? '0 : divisor - 1'b1;
	assign tick = (cnt_ff >= last);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_ff <= '0;
		else
			cnt_ff <= tick ? '0 : cnt_ff + 1'b1;
	end
endmodule

// [testbench/urc_core_monitor.sv]
// Concurrent checks on the host and line ports of the serial register core.
`timescale 1ns/100ps
module urc_core_monitor (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       cs,
	input wire logic [2:0] addr,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       irq,
	input wire logic       serial_in,
	input wire logic       serial_out,
	input wire logic       cts_n,
	input wire logic       dsr_n,
	input wire logic       ri_n,
	input wire logic       cd_n,
	input wire logic       dtr_n,
	input wire logic       rts_n,
	input wire logic       general_output_a_n,
	input wire logic       general_output_b_n
);
	logic rd_q_ff;
	logic wr_q_ff;
	logic rd_take;
	logic wr_take;
	logic id_take;
	// A strobe counts once, on the first cycle it is seen low under chip select.
	assign rd_take = cs && !rd_n && rd_q_ff;
	assign wr_take = cs && !wr_n && wr_q_ff;
	assign id_take = rd_take && addr == 3'h2;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_q_ff <= 1'b1;
			wr_q_ff <= 1'b1;
		end
		else
		begin
			rd_q_ff <= rd_n || !cs;
			wr_q_ff <= wr_n || !cs;
		end
	end
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_rst_pins;
		$rose(arst_n) |-> serial_out && !irq && dtr_n && rts_n && general_output_a_n
			&& general_output_b_n;
	endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pin levels wrong after reset");
	property p_mlc_out;
		(wr_take && addr == 3'h4 && !wdata[4]) |=>
			({general_output_b_n, general_output_a_n, rts_n, dtr_n} == ~$past(wdata[3:0]));
	endproperty
	a_mlc_out: assert property (p_mlc_out) else $error("modem outputs do not follow bits");
	property p_break;
		(wr_take && addr == 3'h3 && wdata[6]) |-> ##3 (!serial_out) [*8];
	endproperty
	a_break: assert property (p_break) else $error("break does not hold line low");
	property p_hold;
		(!rd_take && !$past(rd_take)) |=> $stable(rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without a read");
	property p_id_hi;
		id_take |-> ##[1:2] (rdata[7:4] == 4'h0);
	endproperty
	a_id_hi: assert property (p_id_hi) else $error("ident upper bits not zero");
	property p_id_code;
		id_take |-> ##[1:2] (rdata[3:0] inside {4'h6, 4'h4, 4'h2, 4'h0, 4'h1});
	endproperty
	a_id_code: assert property (p_id_code) else $error("ident code not legal");
	property p_id_idle;
		(id_take && !irq) |-> ##[1:2] (rdata[3:0] == 4'h1);
	endproperty
	a_id_idle: assert property (p_id_idle) else $error("ident shows a source with irq low");
	property p_id_pend;
		(id_take && irq) |-> ##[1:2] (rdata[0] == 1'b0);
	endproperty
	a_id_pend: assert property (p_id_pend) else $error("ident shows none with irq high");
	property p_mlc_hi;
		(rd_take && addr == 3'h4) |-> ##[1:2] (rdata[7:5] == 3'h0);
	endproperty
	a_mlc_hi: assert property (p_mlc_hi) else $error("modem control upper bits not zero");
endmodule

bind urc_core urc_core_monitor mon_u (.clk(clk), .arst_n(arst_n), .cs(cs), .addr(addr),
	.rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .rdata(rdata), .irq(irq),
	.serial_in(serial_in), .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
	.ri_n(ri_n), .cd_n(cd_n), .dtr_n(dtr_n), .rts_n(rts_n),
	.general_output_a_n(general_output_a_n), .general_output_b_n(general_output_b_n));

// [testbench/urc_remote.sv]
// Remote serial station that sends frames to the core and records the frames it sends.
`timescale 1ns/100ps
module urc_remote (
	input  wire logic       clk,
	input  wire logic       line_in,
	input  wire logic [3:0] nb,
	output logic            line_out
);
	logic [11:0] fq[$];
	int          tq[$];
	int          cyc = 0;
	logic [11:0] f;
	always @(posedge clk) cyc <= cyc + 1;
	initial line_out = 1'b1;
	// The divisor stays at one, so a bit lasts sixteen clocks and mid-bit is eight in.
	initial
	begin
		forever
		begin
			@(negedge line_in);
			tq.push_back(cyc);
			f = 12'h000;
			repeat (8) @(posedge clk);
			for (int i = 0; i < nb; i++)
			begin
				repeat (16) @(posedge clk);
				f[i] = line_in;
			end
			fq.push_back(f);
		end
	end
	task automatic send(input logic [11:0] b, input int n);
		@(posedge clk);
		line_out <= 1'b0;
		repeat (16) @(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			line_out <= b[i];
			repeat (16) @(posedge clk);
		end
		line_out <= 1'b1;
	endtask
	task automatic glitch();
		@(posedge clk);
		line_out <= 1'b0;
		repeat (4) @(posedge clk);
		line_out <= 1'b1;
		repeat (200) @(posedge clk);
	endtask
endmodule

// [testbench/test_uart_register_core.sv]
// Self-checking bench for the serial register core.
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) \
	begin $display("[ERR] %s exp %h got %h", n, e, s); failures++; end end
module test_uart_register_core;
	logic       clk;
	logic       arst_n;
	logic       cs;
	logic [2:0] addr;
	logic       rd_n;
	logic       wr_n;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       irq;
	logic       serial_in;
	logic       serial_out;
	logic [3:0] mdm_n;
	logic       dtr_n;
	logic       rts_n;
	logic       out_a_n;
	logic       out_b_n;
	logic [3:0] nbits;
	logic [7:0] v;
	int         failures = 0;
	int         tests_run = 0;
	int         cycles = 0;
	logic [7:0] cf [8] = '{8'h03, 8'h00, 8'h1a, 8'h0d, 8'h2b, 8'h3a, 8'h04, 8'h07};
	urc_core dut_u (.clk(clk), .arst_n(arst_n), .cs(cs), .addr(addr), .rd_n(rd_n),
		.wr_n(wr_n), .wdata(wdata), .rdata(rdata), .irq(irq), .serial_in(serial_in),
		.serial_out(serial_out), .cts_n(mdm_n[0]), .dsr_n(mdm_n[1]), .ri_n(mdm_n[2]),
		.cd_n(mdm_n[3]), .dtr_n(dtr_n), .rts_n(rts_n), .general_output_a_n(out_a_n),
		.general_output_b_n(out_b_n));
	urc_remote rem_u (.clk(clk), .line_in(serial_out), .nb(nbits), .line_out(serial_in));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Whole run is near 6000 cycles; the ceiling leaves ample margin.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			failures++;
			print_verdict();
		end
	end
	function automatic logic [11:0] frm(input logic [7:0] c, input logic [7:0] d);
		int         n;
		logic [7:0] m;
		logic [11:0] f;
		n = 5 + c[1:0];
		m = d & (8'hff >> (8 - n));
		f = {4'h0, m};
		if (c[3])
			f[n] = c[5] ? ~c[4] : (c[4] ? ^m : ~^m);
		f[n + c[3]] = 1'b1;
		f[n + c[3] + 1] = 1'b1;
		return f;
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		cs <= 1'b1;
		addr <= a;
		wdata <= d;
		wr_n <= 1'b0;
		@(posedge clk);
		wr_n <= 1'b1;
		cs <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk);
		cs <= 1'b1;
		addr <= a;
		rd_n <= 1'b0;
		@(posedge clk);
		rd_n <= 1'b1;
		cs <= 1'b0;
		@(posedge clk);
		#1 v = rdata;
	endtask
	task automatic cr(input string n, input logic [2:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		rd(a);
		`CHK(n, e, v & m)
	endtask
	task automatic wl(input logic [7:0] m);
		rd(3'h5);
		for (int i = 0; i < 300 && (v & m) !== m; i++)
			rd(3'h5);
		`CHK("status wait", m, v & m)
	endtask
	task automatic t_regs();
		cr("enable", 3'h1, 8'h00);
		cr("ident", 3'h2, 8'h01);
		cr("lfc", 3'h3, 8'h00);
		cr("status", 3'h5, 8'h60);
		`CHK("pins", 4'hf, {out_b_n, out_a_n, rts_n, dtr_n})
		wr(3'h1, 8'hff);
		cr("enable", 3'h1, 8'h0f);
		wr(3'h4, 8'hef);
		`CHK("pins", 4'h0, {out_b_n, out_a_n, rts_n, dtr_n})
		cr("mlc", 3'h4, 8'h0f);
		wr(3'h4, 8'hff);
		cr("mlc", 3'h4, 8'h1f);
		wr(3'h4, 8'h00);
		wr(3'h3, 8'h80);
		cr("div hi", 3'h1, 8'h00);
		cr("div lo", 3'h0, 8'h01);
		wr(3'h3, 8'h00);
		wr(3'h1, 8'h08);
		rd(3'h6);
		@(posedge clk);
		mdm_n <= 4'he;
		repeat (6) @(posedge clk);
		`CHK("irq", 1'b1, irq)
		cr("ident", 3'h2, 8'h00);
		cr("delta", 3'h6, 8'h01, 8'h0f);
		`CHK("irq", 1'b0, irq)
		@(posedge clk);
		mdm_n <= 4'hf;
		repeat (6) @(posedge clk);
		rd(3'h6);
		wr(3'h1, 8'h00);
		$display("done regs");
	endtask
	task automatic t_tx();
		logic [7:0]  c;
		logic [11:0] m;
		int          n;
		int          g;
		foreach (cf[k])
		begin
			c = cf[k];
			n = 5 + c[1:0];
			m = 12'hfff >> (11 - n - c[3]);
			wr(3'h3, c);
			@(posedge clk);
			nbits <= 4'(n + c[3] + 1);
			wr(3'h0, 8'ha5);
			wr(3'h0, 8'h3c);
			wr(3'h0, 8'hff);
			cr("tx hold full", 3'h5, 8'h00, 8'h20);
			wl(8'h40);
			`CHK("tx hold empty", 8'h20, v & 8'h20)
			repeat (20) @(posedge clk);
			`CHK("frames", 2, rem_u.fq.size())
			`CHK("frame a", frm(c, 8'ha5) & m, rem_u.fq[0])
			`CHK("frame b", frm(c, 8'h3c) & m, rem_u.fq[1])
			g = rem_u.tq[1] - rem_u.tq[0] - 16 * (1 + n + c[3]);
			g = g - (c[2] ? (n == 5 ? 24 : 32) : 16);
			`CHK("stop len", 1'b1, g >= 0 && g <= 3)
			rem_u.fq.delete();
			rem_u.tq.delete();
		end
		$display("done tx");
	endtask
	task automatic t_rx();
		logic [7:0] c;
		int         n;
		foreach (cf[k])
		begin
			c = cf[k];
			n = 5 + c[1:0];
			wr(3'h3, c);
			rem_u.send(frm(c, 8'h96), n + c[3] + 1 + c[2]);
			wl(8'h01);
			`CHK("status", 8'h01, v & 8'h1f)
			cr("rx hold", 3'h0, 8'h96 & (8'hff >> (8 - n)));
			cr("status", 3'h5, 8'h00, 8'h01);
		end
		wr(3'h3, 8'h1b);
		rem_u.send(frm(8'h1b, 8'h96) ^ 12'h100, 10);
		wl(8'h01);
		`CHK("par err", 8'h05, v & 8'h1f)
		rd(3'h0);
		rem_u.send(12'h000, 10);
		wl(8'h01);
		`CHK("break in", 8'h19, v & 8'h1f)
		rd(3'h0);
		rem_u.glitch();
		cr("false start", 3'h5, 8'h00, 8'h01);
		$display("done rx");
	endtask
	task automatic t_irq();
		wr(3'h3, 8'h03);
		@(posedge clk);
		nbits <= 4'h9;
		wr(3'h1, 8'h02);
		wr(3'h0, 8'h55);
		wl(8'h40);
		`CHK("irq", 1'b1, irq)
		cr("ident", 3'h2, 8'h02);
		cr("ident", 3'h2, 8'h01);
		wr(3'h1, 8'h07);
		rem_u.send(frm(8'h03, 8'h11), 9);
		rem_u.send(frm(8'h03, 8'h22), 9);
		`CHK("irq", 1'b1, irq)
		cr("ident", 3'h2, 8'h06);
		cr("ident", 3'h2, 8'h04);
		cr("overrun", 3'h5, 8'h03, 8'h03);
		cr("rx hold kept", 3'h0, 8'h11);
		cr("ident", 3'h2, 8'h01);
		`CHK("irq", 1'b0, irq)
		wr(3'h1, 8'h00);
		rem_u.fq.delete();
		rem_u.tq.delete();
		$display("done irq");
	endtask
	task automatic t_line();
		wr(3'h3, 8'h40);
		repeat (20) @(posedge clk);
		`CHK("break", 1'b0, serial_out)
		wr(3'h3, 8'h03);
		repeat (200) @(posedge clk);
		`CHK("idle", 1'b1, serial_out)
		rem_u.fq.delete();
		wr(3'h4, 8'h10);
		wr(3'h0, 8'h5a);
		wl(8'h01);
		`CHK("loop out", 1'b1, serial_out)
		`CHK("loop wire", 0, rem_u.fq.size())
		cr("loop rx hold", 3'h0, 8'h5a);
		wr(3'h4, 8'h00);
		$display("done line");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		arst_n = 1'b0;
		cs = 1'b0;
		addr = 3'h0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		wdata = 8'h00;
		mdm_n = 4'hf;
		nbits = 4'h9;
		v = 8'h00;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs();
		t_tx();
		t_rx();
		t_irq();
		t_line();
		print_verdict();
	end
endmodule
